//--- sdes_map.vh
// Register map and field layout of the drop-event status block.
// Assumes a 32-bit AHB-Lite slave; register indices map to byte addr x4.
`ifndef SDES_MAP_VH
`define SDES_MAP_VH

`define SDES_IDX_MASK       16'h1C20
`define SDES_IDX_PEND       16'h1C21
`define SDES_ADDR_MASK      18'h0_7080
`define SDES_ADDR_PEND      18'h0_7084
`define SDES_ADDR_W         18

`define SDES_A_VALID_BIT    0
`define SDES_A_PORT_LO      1
`define SDES_A_REASON_LO    3
`define SDES_B_VALID_BIT    7
`define SDES_B_PORT_LO      8
`define SDES_B_REASON_LO    10
`define SDES_PEND_W         14

`define SDES_MASK_RESET     1'b1

`define SDES_RSN_BCAST_LVL  4'h0
`define SDES_RSN_RED        4'h1
`define SDES_RSN_NO_BUF     4'h2
`define SDES_RSN_NO_DESC    4'h3
`define SDES_RSN_NO_DEST    4'h4
`define SDES_RSN_RX_ERR     4'h5
`define SDES_RSN_DROP_LVL   4'h6
`define SDES_RSN_YELLOW     4'h9

`define SDES_PORT_HOST      2'h0
`define SDES_PORT_ONE       2'h1
`define SDES_PORT_TWO       2'h2

`endif

//--- sdes_reason_enc.v
// Encodes one-hot drop causes from the buffer manager into a reason code.
// Assumes causes are same-clock logic; lowest-numbered cause wins.
`include "sdes_map.vh"
`timescale 1ns/1ps
`default_nettype none
module sdes_reason_enc (
  input  wire [7:0] cause,
  output reg  [3:0] reason,
  output wire       any
);
  assign any = |cause;
  always @* begin
    reason = `SDES_RSN_BCAST_LVL;
    if (cause[0]) begin
      reason = `SDES_RSN_BCAST_LVL;
    end else if (cause[1]) begin
      reason = `SDES_RSN_RED;
    end else if (cause[2]) begin
      reason = `SDES_RSN_NO_BUF;
    end else if (cause[3]) begin
      reason = `SDES_RSN_NO_DESC;
    end else if (cause[4]) begin
      reason = `SDES_RSN_NO_DEST;
    end else if (cause[5]) begin
      reason = `SDES_RSN_RX_ERR;
    end else if (cause[6]) begin
      reason = `SDES_RSN_DROP_LVL;
    end else if (cause[7]) begin
      reason = `SDES_RSN_YELLOW;
    end
  end
endmodule
`default_nettype wire

//--- sdes_record.v
// One drop-event record: valid flag, reason and port, clear on read.
// Assumes load and clear come from logic on mclk.
`include "sdes_map.vh"
`timescale 1ns/1ps
`default_nettype none
module sdes_record (
  input  wire       mclk,
  input  wire       resetn,
  input  wire       ce,
  input  wire       load,
  input  wire       clear,
  input  wire [3:0] reason_in,
  input  wire [1:0] port_in,
  output reg        valid_r,
  output reg  [3:0] reason_r,
  output reg  [1:0] port_r
);
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      valid_r  <= 1'b0;
      reason_r <= 4'h0;
      port_r   <= 2'h0;
    end else if (ce) begin
      // Load beats clear so an event in the read cycle survives
      if (load) begin
        valid_r  <= 1'b1;
        reason_r <= reason_in;
        port_r   <= port_in;
      end else if (clear) begin
        valid_r  <= 1'b0;
        reason_r <= 4'h0;
        port_r   <= 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

//--- sdes_drop_status.v
// Drop-event status bank: pending and mask registers on AHB-Lite.
// Assumes drop events arrive as one-cycle pulses on mclk from the
// buffer manager; hsel is decoded outside.
//
// Design decision made here: register access over AHB-Lite.
`include "sdes_map.vh"
`timescale 1ns/1ps
`default_nettype none
module sdes_drop_status (
  input  wire        mclk,
  input  wire        resetn,
  input  wire        ce,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        drop_valid,
  input  wire [7:0]  drop_cause,
  input  wire [1:0]  drop_port,
  output wire        drop_event_irq,
  output wire        set_b_overflow
);
  localparam NSET   = 2;
  localparam RSN_W  = 4;
  localparam PORT_W = 2;

  // Data-phase state of the register bus
  reg                     wr_mask_r;
  reg                     mask_r;
  reg                     mask_nxt;
  reg                     lost_r;
  reg                     lost_nxt;
  reg  [31:0]             hrdata_nxt;

  // Address-phase decode
  wire                    take;
  wire                    take_rd;
  wire                    take_wr;
  wire                    hit_pend;
  wire                    hit_mask;
  wire                    rd_pend;
  wire                    rd_mask;
  wire                    wr_mask;

  // Drop event path
  wire [3:0]              reason;
  wire                    cause_any;
  wire                    ev;
  wire                    clr;
  wire                    both_full;
  wire                    ev_lost;

  // Record sets: index 0 is set A, index 1 is set B
  wire [NSET-1:0]         set_load;
  wire [NSET-1:0]         set_valid;
  wire [NSET*RSN_W-1:0]   set_reason;
  wire [NSET*PORT_W-1:0]  set_port;
  wire                    a_valid;
  wire [3:0]              a_reason;
  wire [1:0]              a_port;
  wire                    b_valid;
  wire [3:0]              b_reason;
  wire [1:0]              b_port;
  wire [`SDES_PEND_W-1:0] pend_word;
  wire [31:0]             pend_read;
  wire [31:0]             mask_read;

  function is_addr;
    input [31:0]              a;
    input [`SDES_ADDR_W-1:0]  adr;
    begin
      is_addr = (a[`SDES_ADDR_W-1:0] == adr) &&
                (a[31:`SDES_ADDR_W] == {(32-`SDES_ADDR_W){1'b0}});
    end
  endfunction

  // Single-cycle slave: no wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  // A transfer offered while ce is low is not taken
  assign take      = hsel & hready & htrans[1] & ce;
  assign take_rd   = take & ~hwrite;
  assign take_wr   = take &  hwrite;
  assign hit_pend  = is_addr(haddr, `SDES_ADDR_PEND);
  assign hit_mask  = is_addr(haddr, `SDES_ADDR_MASK);
  assign rd_pend   = take_rd & hit_pend;
  assign rd_mask   = take_rd & hit_mask;
  // Writes to pending or unmapped words fall through
  assign wr_mask   = take_wr & hit_mask;

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_mask_r <= 1'b0;
    end else if (ce) begin
      wr_mask_r <= wr_mask;
    end
  end

  // Write data stands in the data phase that follows the decode
  always @* begin
    mask_nxt = mask_r;
    if (wr_mask_r) begin
      mask_nxt = hwdata[0];
    end
  end

  sdes_reason_enc u_enc (
    .cause  (drop_cause),
    .reason (reason),
    .any    (cause_any)
  );

  assign ev        = drop_valid & cause_any;
  // Clear on the edge that loads hrdata, so no event slips between
  assign clr       = rd_pend;
  assign both_full = a_valid & b_valid;
  // A keeps the oldest event; B takes the next only while A holds
  assign set_load[0] = ev & (~a_valid | clr);
  assign set_load[1] = ev & a_valid & ~clr & ~b_valid;
  assign ev_lost   = ev & both_full & ~clr;

  // Two independent record sets
  genvar gi;
  generate
    for (gi = 0; gi < NSET; gi = gi + 1) begin : g_set
      sdes_record u_rec (
        .mclk      (mclk),
        .resetn    (resetn),
        .ce        (ce),
        .load      (set_load[gi]),
        .clear     (clr),
        .reason_in (reason),
        .port_in   (drop_port),
        .valid_r   (set_valid[gi]),
        .reason_r  (set_reason[RSN_W*gi +: RSN_W]),
        .port_r    (set_port[PORT_W*gi +: PORT_W])
      );
    end
  endgenerate

  assign a_valid  = set_valid[0];
  assign a_reason = set_reason[3:0];
  assign a_port   = set_port[1:0];
  assign b_valid  = set_valid[1];
  assign b_reason = set_reason[7:4];
  assign b_port   = set_port[3:2];

  assign pend_word = {b_reason,
                      b_port,
                      b_valid,
                      a_reason,
                      a_port,
                      a_valid};
  assign pend_read = {{(32-`SDES_PEND_W){1'b0}}, pend_word};
  assign mask_read = {31'h0000_0000, mask_r};

  // Capture happens whatever the mask holds
  assign drop_event_irq = (a_valid | b_valid) & ~mask_r;
  assign set_b_overflow = lost_r;

  // Loaded at the address phase so the word stands in the data phase
  always @* begin
    hrdata_nxt = hrdata;
    if (rd_pend) begin
      hrdata_nxt = pend_read;
    end else if (rd_mask) begin
      hrdata_nxt = mask_read;
    end else if (take_rd) begin
      hrdata_nxt = 32'h0000_0000;
    end
  end

  // Both sets full and no pending read in the cycle: the event is dropped and flagged
  always @* begin
    lost_nxt = lost_r;
    if (ev_lost) begin
      lost_nxt = 1'b1;
    end else if (clr) begin
      lost_nxt = 1'b0;
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mask_r <= `SDES_MASK_RESET;
      lost_r <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      mask_r <= mask_nxt;
      lost_r <= lost_nxt;
      hrdata <= hrdata_nxt;
    end
  end
endmodule
`default_nettype wire

//--- sdes_drop_status_checker.sv
// Assertions on the ports of the drop-event status bank.
// Assumes hready is fed back from hreadyout by the single-slave bus.
`include "sdes_map.vh"
`timescale 1ns/1ps
`default_nettype none
module sdes_drop_status_checker (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        drop_valid,
  input wire logic        drop_event_irq,
  input wire logic        set_b_overflow
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_rd;
    hsel && hready && htrans[1] && !hwrite && ce;
  endsequence
  sequence s_rd_pend;
    s_rd ##0 (haddr == `SDES_ADDR_PEND);
  endsequence
  sequence s_rd_none;
    s_rd ##0 (haddr != `SDES_ADDR_PEND && haddr != `SDES_ADDR_MASK);
  endsequence
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_read_clears: assert property (
    s_rd_pend ##0 !drop_valid |=>
      !drop_event_irq && !set_b_overflow)
    else $error("pending read did not clear");
  a_unmapped_zero: assert property (s_rd_none |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_b_needs_a: assert property (hrdata[7] |-> hrdata[0])
    else $error("set B valid without set A");
  a_reserved_zero: assert property (hrdata[31:14] == 18'h0)
    else $error("reserved read bits set");
  a_ovf_cause: assert property ($rose(set_b_overflow) |-> $past(drop_valid))
    else $error("overflow without event");
  a_ce_freeze: assert property (
    !ce |=> $stable(set_b_overflow) && $stable(drop_event_irq))
    else $error("state moved with ce low");
endmodule
bind sdes_drop_status sdes_drop_status_checker u_chk (.mclk, .resetn, .ce,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .drop_valid, .drop_event_irq, .set_b_overflow);
`default_nettype wire

//--- tb_sdes_drop_status.sv
// Self-checking bench for the drop-event status bank.
// Assumes one AHB-Lite slave, so hready is its own hreadyout.
`include "sdes_map.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module tb_sdes_drop_status;
  logic        mclk = 0, resetn = 0, ce = 1, hsel = 0, hwrite = 0;
  logic        drop_valid = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0]  htrans = 0, drop_port = 0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  drop_cause = 0;
  wire         hreadyout, hresp, irq, ovf;
  wire  [31:0] hrdata;
  int          bad_count = 0, n_tests = 0;
  always #12.5 mclk = ~mclk;
  sdes_drop_status dut (.mclk, .resetn, .ce, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .drop_valid, .drop_cause, .drop_port, .drop_event_irq(irq),
    .set_b_overflow(ovf));
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge mclk);
    hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= a;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
    #1;
  endtask
  task automatic drop(input logic [7:0] c, input logic [1:0] p);
    @(posedge mclk);
    drop_valid <= 1; drop_cause <= c; drop_port <= p;
    @(posedge mclk);
    drop_valid <= 0;
    #1;
  endtask
  task automatic t_reset;
    bus(0, `SDES_ADDR_MASK, 0); `CHK(rd, 32'h1)
    bus(0, `SDES_ADDR_PEND, 0); `CHK(rd, 32'h0)
    `CHK(irq, 1'b0)
  endtask
  task automatic t_codes;
    logic [3:0] rsn [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};
    bus(1, `SDES_ADDR_MASK, 0);
    for (int i = 0; i < 8; i++) begin
      drop(8'h1 << i, 2'(i % 3)); `CHK(irq, 1'b1)
      bus(0, `SDES_ADDR_PEND, 0);
      `CHK(rd, {25'h0, rsn[i], 2'(i % 3), 1'b1})
      bus(0, `SDES_ADDR_PEND, 0); `CHK(rd, 32'h0)
      `CHK(irq, 1'b0)
    end
  endtask
  task automatic t_two;
    drop(8'h02, 2'h1);
    drop(8'h80, 2'h2); `CHK(ovf, 1'b0)
    drop(8'h04, 2'h0); `CHK(ovf, 1'b1)
    bus(0, `SDES_ADDR_PEND, 0);
    `CHK(rd, {18'h0, 4'h9, 2'h2, 1'b1, 4'h1, 2'h1, 1'b1})
    bus(0, `SDES_ADDR_PEND, 0); `CHK(rd, 32'h0)
    `CHK(ovf, 1'b0)
  endtask
  task automatic t_mask;
    bus(1, `SDES_ADDR_MASK, 1);
    @(posedge mclk) ce <= 0;
    drop(8'h08, 2'h2);
    @(posedge mclk) ce <= 1;
    bus(0, `SDES_ADDR_PEND, 0); `CHK(rd, 32'h0)
    drop(8'h08, 2'h2); `CHK(irq, 1'b0)
    bus(0, `SDES_ADDR_PEND, 0); `CHK(rd, {25'h0, 4'h3, 2'h2, 1'b1})
  endtask
  task automatic t_refuse;
    bus(1, `SDES_ADDR_PEND, 32'hFFFF_FFFF);
    bus(0, `SDES_ADDR_PEND, 0); `CHK(rd, 32'h0)
    bus(0, 32'h10, 0); `CHK(rd, 32'h0)
    bus(1, `SDES_ADDR_MASK, 32'hFFFF_FFFE);
    bus(0, `SDES_ADDR_MASK, 0); `CHK(rd, 32'h0)
  endtask
  task automatic t_b2b;
    drop(8'h10, 2'h1);
    @(posedge mclk);
    hsel <= 1; htrans <= 2'h2; hwrite <= 0; haddr <= `SDES_ADDR_PEND;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    haddr <= `SDES_ADDR_MASK;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
    `CHK(rd, {25'h0, 4'h4, 2'h1, 1'b1})
    hsel <= 0; htrans <= 2'h0;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
    `CHK(rd, 32'h0)
    #1;
    `CHK(irq, 1'b0)
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    resetn <= 1;
    t_reset; t_codes; t_two; t_mask; t_refuse; t_b2b;
    final_report;
  end
  // Whole run is about 125 cycles; this only cuts a hang
  initial begin
    repeat (3000) @(posedge mclk);
    bad_count++;
    final_report;
  end
endmodule
`default_nettype wire
